// file: pkg/ptr_pkg.sv
package ptr_pkg;

  localparam int ADDR_W = 16;
  localparam int IDX_W  = 14;

  // Register indexes; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_GAIN     = 14'h0401;
  localparam logic [IDX_W-1:0] IDX_SGMII    = 14'h0432;
  localparam logic [IDX_W-1:0] IDX_DELAY    = 14'h0446;
  localparam logic [IDX_W-1:0] IDX_ESD      = 14'h0448;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 14'h0470;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 14'h0471;

  localparam logic [3:0] GAIN_RST      = 4'hA;
  localparam logic [3:0] GAIN_UNITY    = 4'h8;
  localparam int         GAIN_STEP_PCT = 2;

  localparam int   SIX_WIRE_BIT = 14;
  localparam logic SIX_WIRE_RST = 1'b0;

  localparam int         TX_DLY_LSB  = 4;
  localparam int         RX_DLY_LSB  = 0;
  localparam logic [3:0] DLY_RST     = 4'h7;
  localparam int         DLY_STEP_PS = 250;

  localparam int         CNT_W        = 6;
  localparam int         MAC_CNT_LSB  = 8;
  localparam int         LINE_CNT_LSB = 0;
  localparam logic [5:0] CNT_MAX      = 6'h3F;

  localparam int         IRQ_MAC_BIT  = 0;
  localparam int         IRQ_LINE_BIT = 1;
  localparam logic [1:0] IRQ_RST      = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: verilog/ptr_regs.sv
// Contract
// R1 - Gain code 0000 is -16%, 1000 unity, 2% steps
// R2 - Gain resets to 1010, RW, upper bits zero
// R3 - Type bit 14 set selects 6-wire, clock pair on
// R4 - Type bit clear: 4-wire, clock pair off
// R5 - Bits 7:4 set transmit delay (code+1)*250ps
// R6 - Bits 3:0 set receive delay, same mapping
// R7 - Delays reset to 0111; upper byte reads zero
// R8 - Count MAC-side ESD activations in bits 13:8
// R9 - Count line-side ESD activations in bits 5:0
// R10 - No dead-time: every activation edge counts
// R11 - Counters cleared by power cycle only
// R12 - Counters saturate at 63, never wrap
//
// The AXI4-Lite interface to the registers was left to the implementer.
module ptr_regs
  import ptr_pkg::*;
(
  input  wire logic                     i_core_clk,
  input  wire logic                     i_srst,
  input  wire logic                     i_por,
  input  wire logic                     i_esd_mac_hit,
  input  wire logic                     i_esd_line_hit,
  input  wire logic                     i_s_axi_awvalid,
  output logic                          o_s_axi_awready,
  input  wire logic [ptr_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic [2:0]               i_s_axi_awprot,
  input  wire logic                     i_s_axi_wvalid,
  output logic                          o_s_axi_wready,
  input  wire logic [31:0]              i_s_axi_wdata,
  input  wire logic [3:0]               i_s_axi_wstrb,
  output logic                          o_s_axi_bvalid,
  input  wire logic                     i_s_axi_bready,
  output logic [1:0]                    o_s_axi_bresp,
  input  wire logic                     i_s_axi_arvalid,
  output logic                          o_s_axi_arready,
  input  wire logic [ptr_pkg::ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic [2:0]               i_s_axi_arprot,
  output logic                          o_s_axi_rvalid,
  input  wire logic                     i_s_axi_rready,
  output logic [31:0]                   o_s_axi_rdata,
  output logic [1:0]                    o_s_axi_rresp,
  output logic [3:0]                    o_line_gain_code,
  output logic signed [5:0]             o_line_gain_pct,
  output logic                          o_sgmii_six_wire,
  output logic                          o_serial_rx_clock_en,
  output logic [3:0]                    o_tx_delay_code,
  output logic [3:0]                    o_rx_delay_code,
  output logic [11:0]                   o_tx_delay_ps,
  output logic [11:0]                   o_rx_delay_ps,
  output logic                          o_irq
);
  import ptr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic              aw_full;
    logic [IDX_W-1:0]  aw_idx;
    logic              w_full;
    logic [15:0]       w_data;
    logic [1:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [15:0]       rdata;
    logic [3:0]        gain;
    logic              six_wire;
    logic [3:0]        tx_dly;
    logic [3:0]        rx_dly;
    logic [1:0]        irq_stat;
    logic [1:0]        irq_mask;
    logic              mac_s1;
    logic              mac_s2;
    logic              mac_prev;
    logic              line_s1;
    logic              line_s2;
    logic              line_prev;
    logic [CNT_W-1:0]  mac_cnt;
    logic [CNT_W-1:0]  line_cnt;
  } ptr_state_t;

  localparam ptr_state_t ST_RST = '{
    aw_idx:   '0,
    w_data:   '0,
    w_strb:   '0,
    bresp:    RESP_OKAY,
    rresp:    RESP_OKAY,
    rdata:    '0,
    gain:     GAIN_RST,
    six_wire: SIX_WIRE_RST,
    tx_dly:   DLY_RST,
    rx_dly:   DLY_RST,
    irq_stat: IRQ_RST,
    irq_mask: IRQ_RST,
    mac_cnt:  '0,
    line_cnt: '0,
    default:  1'b0
  };

  ptr_state_t st;
  ptr_state_t next_st;
  ptr_state_t keep_st;
  logic       mac_evt;
  logic       line_evt;
  logic       aw_take;
  logic       w_take;
  logic       ar_take;
  logic [17:0] rd_word;

  //////////////////////////////////////////////////////////////////////////////

  // Returns the response code in the top two bits and the register word below.
  function automatic logic [17:0] read_reg(input logic [IDX_W-1:0] idx,
                                           input ptr_state_t       s);
    logic [15:0] d;
    logic [1:0]  r;
    d = '0;
    r = RESP_OKAY;
    unique case (idx)
      IDX_GAIN:     d[3:0] = s.gain; // R2
      IDX_SGMII:    d[SIX_WIRE_BIT] = s.six_wire;
      IDX_DELAY: begin
        d[TX_DLY_LSB +: 4] = s.tx_dly; // R7
        d[RX_DLY_LSB +: 4] = s.rx_dly;
      end
      IDX_ESD: begin
        d[MAC_CNT_LSB +: CNT_W]  = s.mac_cnt; // R8
        d[LINE_CNT_LSB +: CNT_W] = s.line_cnt; // R9
      end
      IDX_IRQ_STAT: d[1:0] = s.irq_stat;
      IDX_IRQ_MASK: d[1:0] = s.irq_mask;
      default:      r = RESP_SLVERR;
    endcase
    return {r, d};
  endfunction

  // Delay in picoseconds for a clock-path code.
  function automatic logic [11:0] delay_ps(input logic [3:0] code);
    logic [15:0] p;
    p = (16'(code) + 16'h0001) * 16'(DLY_STEP_PS);
    return p[11:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  assign aw_take = i_s_axi_awvalid && o_s_axi_awready;
  assign w_take  = i_s_axi_wvalid && o_s_axi_wready;
  assign ar_take = i_s_axi_arvalid && o_s_axi_arready;
  assign rd_word = read_reg(i_s_axi_araddr[ADDR_W-1:2], st);

  // The edge detectors look at the second stage only; the first stage may be
  // metastable. Each rising edge is one activation, with no merging.
  assign mac_evt  = st.mac_s2 && !st.mac_prev; // R10
  assign line_evt = st.line_s2 && !st.line_prev; // R10

  always_comb begin
    next_st = st;
    keep_st = st;

    // Both hit inputs are asynchronous pins; they pass two flops first.
    next_st.mac_s1    = i_esd_mac_hit;
    next_st.mac_s2    = st.mac_s1;
    next_st.mac_prev  = st.mac_s2;
    next_st.line_s1   = i_esd_line_hit;
    next_st.line_s2   = st.line_s1;
    next_st.line_prev = st.line_s2;

    // Saturating keeps a burst of events from reading back as a small count.
    if (mac_evt && st.mac_cnt != CNT_MAX) begin // R12
      next_st.mac_cnt = st.mac_cnt + 6'h01; // R8
    end
    if (line_evt && st.line_cnt != CNT_MAX) begin // R12
      next_st.line_cnt = st.line_cnt + 6'h01; // R9
    end

    if (aw_take) begin
      next_st.aw_full = 1'b1;
      next_st.aw_idx  = i_s_axi_awaddr[ADDR_W-1:2];
    end
    if (w_take) begin
      next_st.w_full = 1'b1;
      next_st.w_data = i_s_axi_wdata[15:0];
      next_st.w_strb = i_s_axi_wstrb[1:0];
    end
    if (st.bvalid && i_s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // Address and data may arrive in either order; the update waits for both
    // and raises the response in the same edge, so a read after it sees it.
    if (st.aw_full && st.w_full && !st.bvalid) begin
      next_st.aw_full = 1'b0;
      next_st.w_full  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = RESP_OKAY;
      unique case (st.aw_idx)
        IDX_GAIN: begin
          if (st.w_strb[0]) begin
            next_st.gain = st.w_data[3:0]; // R2
          end
        end
        IDX_SGMII: begin
          if (st.w_strb[1]) begin
            next_st.six_wire = st.w_data[SIX_WIRE_BIT]; // R3
          end
        end
        IDX_DELAY: begin
          if (st.w_strb[0]) begin
            next_st.tx_dly = st.w_data[TX_DLY_LSB +: 4]; // R5
            next_st.rx_dly = st.w_data[RX_DLY_LSB +: 4]; // R6
          end
        end
        IDX_ESD: begin
          // Counters are read-only; the write is accepted and has no effect.
          next_st.bresp = RESP_OKAY;
        end
        IDX_IRQ_STAT: begin
          if (st.w_strb[0]) begin
            next_st.irq_stat = st.irq_stat & ~st.w_data[1:0];
          end
        end
        IDX_IRQ_MASK: begin
          if (st.w_strb[0]) begin
            next_st.irq_mask = st.w_data[1:0];
          end
        end
        default: next_st.bresp = RESP_SLVERR;
      endcase
    end

    // Applied after the clear so that an event in the clearing cycle is kept.
    if (mac_evt) begin
      next_st.irq_stat[IRQ_MAC_BIT] = 1'b1;
    end
    if (line_evt) begin
      next_st.irq_stat[IRQ_LINE_BIT] = 1'b1;
    end

    if (st.rvalid && i_s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = rd_word[17:16];
      next_st.rdata  = rd_word[15:0];
    end

    // Pin reset returns everything but the ESD counters and their detectors,
    // which belong to the power-on domain only.
    if (i_srst) begin
      keep_st           = next_st;
      next_st           = ST_RST;
      next_st.mac_s1    = keep_st.mac_s1;
      next_st.mac_s2    = keep_st.mac_s2;
      next_st.mac_prev  = keep_st.mac_prev;
      next_st.line_s1   = keep_st.line_s1;
      next_st.line_s2   = keep_st.line_s2;
      next_st.line_prev = keep_st.line_prev;
      next_st.mac_cnt   = keep_st.mac_cnt; // R11
      next_st.line_cnt  = keep_st.line_cnt; // R11
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_por) begin
      st <= ST_RST; // R11
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // One write and one read are in flight at most; ready drops while held.
  assign o_s_axi_awready = !st.aw_full && !st.bvalid;
  assign o_s_axi_wready  = !st.w_full && !st.bvalid;
  assign o_s_axi_arready = !st.rvalid;
  assign o_s_axi_bvalid  = st.bvalid;
  assign o_s_axi_bresp   = st.bresp;
  assign o_s_axi_rvalid  = st.rvalid;
  assign o_s_axi_rresp   = st.rresp;
  assign o_s_axi_rdata   = {16'h0000, st.rdata};

  assign o_line_gain_code = st.gain;
  // Signed percent change: code 0 gives -16, code 8 gives none.
  assign o_line_gain_pct  = 6'(($signed({2'b00, st.gain}) - $signed({2'b00, GAIN_UNITY}))
                              * GAIN_STEP_PCT); // R1

  assign o_sgmii_six_wire     = st.six_wire; // R3
  assign o_serial_rx_clock_en = st.six_wire; // R4

  assign o_tx_delay_code = st.tx_dly;
  assign o_rx_delay_code = st.rx_dly;
  assign o_tx_delay_ps   = delay_ps(st.tx_dly); // R5
  assign o_rx_delay_ps   = delay_ps(st.rx_dly); // R6

  // A level output: it stays high until software clears or masks the status,
  // so an event that the handler misses is never lost.
  assign o_irq = |(st.irq_stat & st.irq_mask);

endmodule

// file: tb/ptr_regs_props.sv
module ptr_regs_props
  import ptr_pkg::*;
(
  input wire logic              i_core_clk,
  input wire logic              i_srst,
  input wire logic              i_por,
  input wire logic              i_s_axi_rready,
  input wire logic              o_s_axi_rvalid,
  input wire logic [31:0]       o_s_axi_rdata,
  input wire logic [3:0]        o_line_gain_code,
  input wire logic signed [5:0] o_line_gain_pct,
  input wire logic              o_sgmii_six_wire,
  input wire logic              o_serial_rx_clock_en,
  input wire logic [3:0]        o_tx_delay_code,
  input wire logic [3:0]        o_rx_delay_code,
  input wire logic [11:0]       o_tx_delay_ps,
  input wire logic [11:0]       o_rx_delay_ps
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst || i_por);
  a_gain_pct: assert property (o_line_gain_pct == ($signed({2'h0, o_line_gain_code}) - 8) * 2)
    else $error("gain percent off");
  a_gain_reset: assert property ($past(i_srst) |-> o_line_gain_code == GAIN_RST)
    else $error("gain reset value");
  a_clock_pair: assert property (o_serial_rx_clock_en == o_sgmii_six_wire)
    else $error("rx clock pair mismatch");
  a_tx_delay: assert property (o_tx_delay_ps == (o_tx_delay_code + 1) * DLY_STEP_PS)
    else $error("tx delay off");
  a_rx_delay: assert property (o_rx_delay_ps == (o_rx_delay_code + 1) * DLY_STEP_PS)
    else $error("rx delay off");
  a_delay_reset: assert property ($past(i_srst) |-> {o_tx_delay_code, o_rx_delay_code} == 8'h77)
    else $error("delay reset value");
  a_upper_zero: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_read_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> $stable(o_s_axi_rdata))
    else $error("read data moved");
  cover property (o_sgmii_six_wire);
  cover property (o_line_gain_code == 4'h0);
  cover property (o_s_axi_rvalid && i_s_axi_rready);
endmodule

bind ptr_regs ptr_regs_props props_u (.*);

// file: tb/ptr_regs_tb_top.sv
module ptr_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ptr_pkg::*;
  logic              i_core_clk = 1'h0, i_srst = 1'h1, i_por = 1'h1;
  logic              i_esd_mac_hit = 1'h0, i_esd_line_hit = 1'h0, i_s_axi_awvalid = 1'h0;
  logic              i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0, i_s_axi_arvalid = 1'h0;
  logic              i_s_axi_rready = 1'h0, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
  logic              o_s_axi_arready, o_s_axi_rvalid, o_sgmii_six_wire, o_serial_rx_clock_en;
  logic              o_irq;
  logic [15:0]       i_s_axi_awaddr = '0, i_s_axi_araddr = '0;
  logic [2:0]        i_s_axi_awprot = '0, i_s_axi_arprot = '0;
  logic [31:0]       i_s_axi_wdata = '0, o_s_axi_rdata;
  logic [3:0]        i_s_axi_wstrb = 4'hF, o_line_gain_code, o_tx_delay_code, o_rx_delay_code;
  logic [1:0]        o_s_axi_bresp, o_s_axi_rresp;
  logic signed [5:0] o_line_gain_pct;
  logic [11:0]       o_tx_delay_ps, o_rx_delay_ps;
  logic [33:0]       rq[$];
  logic [1:0]        bq[$];
  logic [5:0]        em, el;
  logic [7:0]        d;
  int                num_errors = 0, checks_done = 0, i;

  always #2 i_core_clk = ~i_core_clk;
  ptr_regs dut_u (.*);
  ////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [33:0] e, logic [33:0] g);
    checks_done++;
    if (e !== g) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // Answers are matched in order, so an extra response shows as a mismatch; a lost one stalls the task until the watchdog.
  always @(posedge i_core_clk) begin
    if (o_s_axi_rvalid && i_s_axi_rready) chk("read", rq.pop_front(), {o_s_axi_rresp, o_s_axi_rdata});
    if (o_s_axi_bvalid && i_s_axi_bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, o_s_axi_bresp});
  end
  task automatic wr(logic [13:0] x, logic [15:0] v, logic [1:0] r = RESP_OKAY);
    bq.push_back(r);
    i_s_axi_awaddr <= {x, 2'h0};
    i_s_axi_wdata <= {16'h0000, v};
    i_s_axi_awvalid <= 1'h1;
    i_s_axi_wvalid <= 1'h1;
    do begin
      @(posedge i_core_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
      if (o_s_axi_bvalid && !i_s_axi_bready) i_s_axi_bready <= 1'h1;
    end while (!(o_s_axi_bvalid && i_s_axi_bready));
    i_s_axi_bready <= 1'h0;
  endtask
  task automatic rd(logic [13:0] x, logic [15:0] v, logic [1:0] r = RESP_OKAY);
    rq.push_back({r, 16'h0000, v});
    i_s_axi_araddr <= {x, 2'h0};
    i_s_axi_arvalid <= 1'h1;
    do begin
      @(posedge i_core_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
      // Ready lags valid by a cycle so the read data is seen held while waiting.
      if (o_s_axi_rvalid && !i_s_axi_rready) i_s_axi_rready <= 1'h1;
    end while (!(o_s_axi_rvalid && i_s_axi_rready));
    i_s_axi_rready <= 1'h0;
  endtask
  // Low for three cycles so the synchroniser sees every pulse as its own event.
  task automatic hit(logic m, int k);
    repeat (k) begin
      if (m) i_esd_mac_hit <= 1'h1;
      else i_esd_line_hit <= 1'h1;
      repeat (2) @(posedge i_core_clk);
      i_esd_mac_hit <= 1'h0;
      i_esd_line_hit <= 1'h0;
      repeat (3) @(posedge i_core_clk);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge i_core_clk);
    num_errors++;
    print_verdict;
  end
  initial begin
    void'($urandom(32'h7C4B694A));
    repeat (5) @(posedge i_core_clk);
    i_srst <= 1'h0;
    i_por <= 1'h0;
    @(posedge i_core_clk);
    rd(IDX_GAIN, 16'h000A);
    rd(IDX_SGMII, 16'h0000);
    rd(IDX_DELAY, 16'h0077);
    rd(IDX_ESD, 16'h0000);
    wr(14'h0000, 16'hFFFF, RESP_SLVERR);
    rd(14'h0000, 16'h0000, RESP_SLVERR);
    for (i = 0; i < 16; i++) begin
      wr(IDX_GAIN, 16'hFFF0 | 16'(i));
      rd(IDX_GAIN, 16'(i));
      chk("gain_pct", {28'h0, 6'((i - 8) * 2)}, {28'h0, o_line_gain_pct});
      chk("gain_code", 34'(i), {30'h0, o_line_gain_code});
    end
    for (i = 0; i < 6; i++) begin
      d = (i < 2) ? (i ? 8'hF0 : 8'h0F) : 8'($urandom);
      wr(IDX_DELAY, {8'hFF, d});
      rd(IDX_DELAY, {8'h00, d});
      chk("tx_ps", 34'((d[7:4] + 1) * DLY_STEP_PS), {22'h0, o_tx_delay_ps});
      chk("rx_ps", 34'((d[3:0] + 1) * DLY_STEP_PS), {22'h0, o_rx_delay_ps});
      chk("tx_code", {30'h0, d[7:4]}, {30'h0, o_tx_delay_code});
      chk("rx_code", {30'h0, d[3:0]}, {30'h0, o_rx_delay_code});
    end
    for (i = 0; i < 2; i++) begin
      wr(IDX_SGMII, i ? 16'hFFFF : 16'hBFFF);
      rd(IDX_SGMII, i ? 16'h4000 : 16'h0000);
      chk("rx_clk_en", 34'(i), {33'h0, o_serial_rx_clock_en});
      chk("six_wire", 34'(i), {33'h0, o_sgmii_six_wire});
    end
    em = 6'($urandom_range(9, 1));
    el = 6'($urandom_range(9, 1));
    wr(IDX_IRQ_MASK, 16'h0001);
    hit(1'h1, em);
    chk("irq", 34'h1, {33'h0, o_irq});
    wr(IDX_ESD, 16'hFFFF);
    rd(IDX_ESD, {2'h0, em, 8'h00});
    wr(IDX_IRQ_STAT, 16'h0003);
    hit(1'h0, el);
    chk("irq", 34'h0, {33'h0, o_irq});
    rd(IDX_IRQ_STAT, 16'h0002);
    rd(IDX_ESD, {2'h0, em, 2'h0, el});
    hit(1'h1, 70);
    rd(IDX_ESD, {2'h0, CNT_MAX, 2'h0, el});
    i_srst <= 1'h1;
    hit(1'h0, 1);
    i_srst <= 1'h0;
    @(posedge i_core_clk);
    rd(IDX_ESD, {2'h0, CNT_MAX, 2'h0, el + 6'h1});
    rd(IDX_GAIN, 16'h000A);
    print_verdict;
  end
endmodule
